// ### pks_map.svh
// constants for the panel led and key matrix scanner
`ifndef PKS_MAP_SVH
`define PKS_MAP_SVH

`define PKS_CLK_PERIOD_NS      10
`define PKS_LED_COLS           4
`define PKS_LED_ROWS           8
`define PKS_KEY_ROWS           11
`define PKS_KEY_COLS           12
`define PKS_LED_COL_DWELL_NS   1000000
`define PKS_LED_COL_DWELL_CYC  ((`PKS_LED_COL_DWELL_NS + `PKS_CLK_PERIOD_NS - 1) / `PKS_CLK_PERIOD_NS)
`define PKS_KEY_ROW_DWELL_NS   100000
`define PKS_KEY_ROW_DWELL_CYC  ((`PKS_KEY_ROW_DWELL_NS + `PKS_CLK_PERIOD_NS - 1) / `PKS_CLK_PERIOD_NS)
`define PKS_KEY_SETTLE_NS      5000
`define PKS_KEY_SETTLE_CYC     ((`PKS_KEY_SETTLE_NS + `PKS_CLK_PERIOD_NS - 1) / `PKS_CLK_PERIOD_NS)
`define PKS_DEBOUNCE_SCANS     3
`define PKS_LED_COL_RST        4'h1
`define PKS_LED_ROW_RST        8'hff
`define PKS_KEY_ROW_RST        11'h001

`endif

// ### pks_pkg.sv
// types for the panel led and key matrix scanner
`default_nettype none
`include "pks_map.svh"

package pks_pkg;
    typedef logic [`PKS_LED_COLS-1:0]                 pks_led_col_t;
    typedef logic [`PKS_LED_ROWS-1:0]                 pks_led_row_t;
    typedef logic [`PKS_LED_COLS*`PKS_LED_ROWS-1:0]   pks_led_pat_t;
    typedef logic [`PKS_KEY_ROWS-1:0]                 pks_key_row_t;
    typedef logic [`PKS_KEY_COLS-1:0]                 pks_key_col_t;
    typedef logic [3:0]                               pks_idx_t;
    typedef logic [16:0]                              pks_cnt_t;
    typedef enum logic { PKS_PH_SETTLE, PKS_PH_HOLD } pks_phase_t;
endpackage

`default_nettype wire

// ### pks_led_if.sv
// carrier between the scanner top and the led column driver
`default_nettype none

interface pks_led_if;
    import pks_pkg::*;
    pks_led_pat_t pattern;
    pks_led_col_t col_en;
    pks_led_row_t row_n;
    modport drv (input pattern, output col_en, output row_n);
    modport ctl (output pattern, input col_en, input row_n);
endinterface

`default_nettype wire

// ### pks_led_drive.sv
// led matrix column multiplexer
`default_nettype none
`include "pks_map.svh"

module pks_led_drive
    import pks_pkg::*;
#(
    parameter int COL_DWELL_CYC = `PKS_LED_COL_DWELL_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    pks_led_if.drv   led
);
    pks_cnt_t     tick_q;
    logic [1:0]   col_q;
    logic [1:0]   col_d;
    logic         wrap;
    pks_led_col_t col_en_q;
    pks_led_row_t row_n_q;

    assign wrap = (tick_q == pks_cnt_t'(COL_DWELL_CYC - 1));

    always_comb begin
        col_d = wrap ? col_q + 2'h1 : col_q;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tick_q <= '0;
        end else if (wrap) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 17'h00001;
        end
    end

    // one column group at a time, high enables its anodes
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            col_q    <= 2'h0;
            col_en_q <= `PKS_LED_COL_RST;
        end else begin
            col_q    <= col_d;                          // R1
            col_en_q <= pks_led_col_t'(4'h1 << col_d);  // R2
        end
    end

    // low sinks the cathodes of lit leds in the active column
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            row_n_q <= `PKS_LED_ROW_RST;
        end else begin
            row_n_q <= ~led.pattern[{col_d, 3'h0} +: `PKS_LED_ROWS];  // R3 R4
        end
    end

    assign led.col_en = col_en_q;
    assign led.row_n  = row_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    col_onehot_a: assert property (@(posedge core_clk) disable iff (!rstn)  // R1
        $onehot(col_en_q))
        else $error("led column enable not one-hot");

    col_change_a: assert property (@(posedge core_clk) disable iff (!rstn)  // R2
        $past(rstn) && $changed(col_en_q) |-> $past(wrap))
        else $error("led column moved before its dwell ended");

    row_match_a: assert property (@(posedge core_clk) disable iff (!rstn)  // R4
        $past(rstn) |-> row_n_q == pks_led_row_t'(~($past(led.pattern) >> {col_q, 3'h0})))
        else $error("led rows do not follow the pattern of the lit column");
endmodule // pks_led_drive

`default_nettype wire

// ### pks_scan_top.sv
// panel led matrix driver and key matrix scanner
// What this block does
// R1 - LED matrix has four column groups; columns and rows driven separately.
// R2 - A column is enabled by driving its control output high.
// R3 - A row is enabled by driving its control output low.
// R4 - An LED lights only where its column and row enables coincide.
// R5 - Key matrix of eleven driven rows and twelve sensed columns.
// R6 - Test signal drives key rows one at a time, in sequence.
// R7 - Pressed key couples the driven row onto its column; columns are watched.
// R8 - Key identity is driven row number combined with the sensing column number.
// R9 - Sample after settling; report presses only after several stable scans.
`default_nettype none
`include "pks_map.svh"

module pks_scan_top
    import pks_pkg::*;
#(
    parameter int ROW_DWELL_CYC = `PKS_KEY_ROW_DWELL_CYC,
    parameter int COL_DWELL_CYC = `PKS_LED_COL_DWELL_CYC
) (
    input  wire logic   core_clk,
    input  wire logic   rstn,
    input  wire logic [31:0] led_pattern,
    output var  logic [3:0]  led_col_en,
    output var  logic [7:0]  led_row_n,
    output var  logic [10:0] key_row_out,
    input  wire logic [11:0] key_col_in,
    output var  logic        key_press,
    output var  logic        key_release,
    output var  logic        key_held,
    output var  logic [3:0]  key_row_idx,
    output var  logic [3:0]  key_col_idx
);
    localparam logic [1:0] DEB = 2'(`PKS_DEBOUNCE_SCANS);

    pks_led_if    led_bus ();
    pks_key_col_t col_meta_q;
    pks_key_col_t col_sync_q;
    pks_cnt_t     dwell_q;
    pks_phase_t   phase_q;
    pks_idx_t     row_idx_q;
    pks_key_row_t key_row_q;
    logic         row_end;
    logic         frame_end;
    logic         sample;
    logic         frame_hit_q;
    pks_idx_t     frame_row_q;
    pks_idx_t     frame_col_q;
    logic         prev_hit_q;
    logic [7:0]   prev_code_q;
    logic [1:0]   stable_q;
    logic [1:0]   stable_d;
    logic         same;
    logic         press_q;
    logic         release_q;
    logic         held_q;
    pks_idx_t     hrow_q;
    pks_idx_t     hcol_q;

    function automatic pks_idx_t first_col(input pks_key_col_t c);
        pks_idx_t r;
        r = 4'h0;
        for (int i = `PKS_KEY_COLS - 1; i >= 0; i--) begin
            if (c[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // led side
    assign led_bus.pattern = led_pattern;

    pks_led_drive #(
        .COL_DWELL_CYC (COL_DWELL_CYC)
    ) u_led (
        .core_clk (core_clk),
        .rstn     (rstn),
        .led      (led_bus.drv)
    );

    assign led_col_en = led_bus.col_en;
    assign led_row_n  = led_bus.row_n;

    ////////////////////////////////////////////////////////////////////////////////
    // column pins into the clock domain
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            col_meta_q <= '0;
            col_sync_q <= '0;
        end else begin
            col_meta_q <= key_col_in;  // R5
            col_sync_q <= col_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // row stepping; settle must stay below the row dwell
    assign row_end   = (dwell_q == pks_cnt_t'(ROW_DWELL_CYC - 1));
    assign frame_end = row_end && (row_idx_q == 4'(`PKS_KEY_ROWS - 1));
    assign sample    = (phase_q == PKS_PH_SETTLE) &&
                       (dwell_q == pks_cnt_t'(`PKS_KEY_SETTLE_CYC));

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dwell_q <= '0;
        end else if (row_end) begin
            dwell_q <= '0;
        end else begin
            dwell_q <= dwell_q + 17'h00001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase_q <= PKS_PH_SETTLE;
        end else begin
            unique case (phase_q)
                PKS_PH_SETTLE: if (sample) begin
                    phase_q <= PKS_PH_HOLD;  // R9
                end
                PKS_PH_HOLD: if (row_end) begin
                    phase_q <= PKS_PH_SETTLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            row_idx_q <= 4'h0;
            key_row_q <= `PKS_KEY_ROW_RST;
        end else if (row_end) begin
            row_idx_q <= frame_end ? 4'h0 : row_idx_q + 4'h1;                  // R6
            key_row_q <= frame_end ? `PKS_KEY_ROW_RST : {key_row_q[9:0], 1'b0};  // R6
        end
    end

    assign key_row_out = key_row_q;

    ////////////////////////////////////////////////////////////////////////////////
    // first coupled key of a frame
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            frame_hit_q <= 1'b0;
            frame_row_q <= 4'h0;
            frame_col_q <= 4'h0;
        end else if (frame_end) begin
            frame_hit_q <= 1'b0;
        end else if (sample && |col_sync_q && !frame_hit_q) begin
            frame_hit_q <= 1'b1;                   // R7
            frame_row_q <= row_idx_q;              // R8
            frame_col_q <= first_col(col_sync_q);  // R8
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // debounce across whole scans
    always_comb begin
        same = (frame_hit_q == prev_hit_q) &&
               (!frame_hit_q || {frame_row_q, frame_col_q} == prev_code_q);
        if (!same) begin
            stable_d = 2'h1;
        end else if (stable_q == DEB) begin
            stable_d = DEB;
        end else begin
            stable_d = stable_q + 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            prev_hit_q  <= 1'b0;
            prev_code_q <= 8'h00;
            stable_q    <= 2'h0;
        end else if (frame_end) begin
            prev_hit_q  <= frame_hit_q;
            prev_code_q <= {frame_row_q, frame_col_q};
            stable_q    <= stable_d;  // R9
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            press_q   <= 1'b0;
            release_q <= 1'b0;
            held_q    <= 1'b0;
            hrow_q    <= 4'h0;
            hcol_q    <= 4'h0;
        end else begin
            press_q   <= 1'b0;
            release_q <= 1'b0;
            if (frame_end && stable_d == DEB) begin
                if (frame_hit_q &&
                    (!held_q || {frame_row_q, frame_col_q} != {hrow_q, hcol_q})) begin
                    press_q <= 1'b1;  // R9
                    held_q  <= 1'b1;
                    hrow_q  <= frame_row_q;
                    hcol_q  <= frame_col_q;
                end else if (!frame_hit_q && held_q) begin
                    release_q <= 1'b1;
                    held_q    <= 1'b0;
                end
            end
        end
    end

    assign key_press   = press_q;
    assign key_release = release_q;
    assign key_held    = held_q;
    assign key_row_idx = hrow_q;
    assign key_col_idx = hcol_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence row_moved;
        $changed(key_row_q);
    endsequence

    sequence row_still;
        $stable(key_row_q) [*8];
    endsequence

    row_onehot_a: assert property ($onehot(key_row_q))  // R6
        else $error("key rows not driven one at a time");

    row_step_a: assert property (($past(rstn) and row_moved) |->  // R6
        key_row_q == ($past(key_row_q) == 11'h400 ? 11'h001 : $past(key_row_q) << 1))
        else $error("key row skipped or reversed");

    row_dwell_a: assert property (($past(rstn) and row_moved) |=> row_still)  // R9
        else $error("key row left too early");

    sample_settle_a: assert property (sample |->  // R9
        dwell_q == pks_cnt_t'(`PKS_KEY_SETTLE_CYC) && $stable(key_row_q))
        else $error("columns sampled before settling");

    hit_capture_a: assert property (sample && |col_sync_q && !frame_hit_q && !frame_end  // R8
        |=> frame_hit_q && frame_row_q == $past(row_idx_q)
            && frame_col_q == first_col($past(col_sync_q)))
        else $error("coupled key not captured with its row and column");

    hit_needs_col_a: assert property ($rose(frame_hit_q) |-> $past(|col_sync_q))  // R7
        else $error("key captured with no column coupling");

    press_code_a: assert property (key_press |->  // R8
        {key_row_idx, key_col_idx} == $past({frame_row_q, frame_col_q}) && key_held)
        else $error("reported key code differs from scanned key");

    press_stable_a: assert property (key_press || key_release |->  // R9
        $past(frame_end) && stable_q == DEB)
        else $error("key event reported before enough stable scans");
endmodule // pks_scan_top

`default_nettype wire

// ### pks_panel_model.sv
// passive led matrix and key switch matrix on the panel side
`default_nettype none

module pks_panel_model (
    input  wire logic        [3:0]  led_col_en,
    input  wire logic        [7:0]  led_row_n,
    input  wire logic        [10:0] key_row_out,
    input  wire logic               key_down,
    input  wire logic        [3:0]  key_row_sel,
    input  wire logic        [3:0]  key_col_sel,
    output var  logic        [11:0] key_col_in,
    output var  logic        [31:0] led_lit
);
    timeunit 1ns;
    timeprecision 1ps;

    // columns have pull-downs, so an open switch reads low
    always_comb begin
        key_col_in = 12'h000;
        if (key_down)
            key_col_in[key_col_sel] = key_row_out[key_row_sel];
    end

    always_comb begin
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 8; r++)
                led_lit[c*8+r] = led_col_en[c] & ~led_row_n[r];
    end
endmodule // pks_panel_model

`default_nettype wire

// ### tb_panel_led_key_matrix_scanner.sv
// self-checking testbench for the panel led and key matrix scanner
`default_nettype none
`include "pks_map.svh"

module tb_panel_led_key_matrix_scanner;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int ROW_DW = 600;
    localparam int COL_DW = 8;
    localparam int FRAME  = ROW_DW * `PKS_KEY_ROWS;
    // fifteen key frames, room for the ring walks and three key events
    localparam int LIMIT  = 99000;

    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [31:0] led_pattern = 32'h0;
    logic        key_down = 1'b0;
    logic [3:0]  krow = 4'h0;
    logic [3:0]  kcol = 4'h0;
    logic [3:0]  led_col_en;
    logic [7:0]  led_row_n;
    logic [10:0] key_row_out;
    logic [11:0] key_col_in;
    logic [31:0] led_lit;
    logic        key_press, key_release, key_held;
    logic [3:0]  key_row_idx, key_col_idx;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;

    pks_scan_top #(.ROW_DWELL_CYC(ROW_DW), .COL_DWELL_CYC(COL_DW)) pks_scan_top_inst (
        .core_clk(core_clk), .rstn(rstn), .led_pattern(led_pattern),
        .led_col_en(led_col_en), .led_row_n(led_row_n), .key_row_out(key_row_out),
        .key_col_in(key_col_in), .key_press(key_press), .key_release(key_release),
        .key_held(key_held), .key_row_idx(key_row_idx), .key_col_idx(key_col_idx));

    pks_panel_model pks_panel_model_inst (
        .led_col_en(led_col_en), .led_row_n(led_row_n), .key_row_out(key_row_out),
        .key_down(key_down), .key_row_sel(krow), .key_col_sel(kcol),
        .key_col_in(key_col_in), .led_lit(led_lit));

    always #5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        @(negedge core_clk);
        chk("reset col", 4'h1, led_col_en);
        chk("reset rows", 8'hff, led_row_n);
        chk("reset key row", 11'h001, key_row_out);
        chk("reset held", 1'b0, key_held);
        @(posedge core_clk);
        rstn <= 1'b1;
        $display("reset test done");
    endtask

    // one-hot ring: step order, dwell length and, for leds, the row drive
    task automatic watch_ring(input bit keys, input int n, input int dwell, input int cycles);
        logic [10:0] prev, cur, mask;
        int run, moves, c;
        mask = 11'h7ff >> (11 - n);
        prev = keys ? key_row_out : {7'h0, led_col_en};
        run = -1;
        moves = 0;
        repeat (cycles) begin
            @(negedge core_clk);
            cur = keys ? key_row_out : {7'h0, led_col_en};
            if (cur !== prev) begin
                chk("ring step", ((prev << 1) | (prev >> (n - 1))) & mask, cur);
                if (run >= 0)
                    chk("ring dwell", dwell, run + 1);
                run = 0;
                moves++;
            end else if (run >= 0)
                run++;
            prev = cur;
            chk("ring onehot", 1'b1, $onehot(cur));
            chk("idle press", 1'b0, key_press);
            if (!keys) begin
                c = 0;
                for (int k = 0; k < 4; k++)
                    if (led_col_en[k])
                        c = k;
                chk("row drive", 8'(~led_pattern[c*8 +: 8]), led_row_n);
                chk("lit leds", led_pattern & (32'hff << (c*8)), led_lit);
            end
        end
        chk("ring moves", 1'b1, moves >= n);
        $display("ring test done");
    endtask

    // press, move to another key, or let go, then await the debounced event
    task automatic key_event(input bit down, input logic [3:0] r, input logic [3:0] col);
        int n, wrong;
        @(posedge core_clk);
        key_down <= down;
        krow <= r;
        kcol <= col;
        n = 0;
        wrong = 0;
        while ((down ? key_press : key_release) !== 1'b1 && n < 5 * FRAME) begin
            @(negedge core_clk);
            n++;
            if ((down ? key_release : key_press) === 1'b1)
                wrong++;
        end
        chk("event delay", 1'b1, n > 2 * FRAME && n < 5 * FRAME);
        chk("stray event", 0, wrong);
        chk("held", down, key_held);
        if (down) begin
            chk("key row", r, key_row_idx);
            chk("key col", col, key_col_idx);
        end
        @(negedge core_clk);
        chk("pulse width", 1'b0, key_press | key_release);
        $display("key event test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        test_reset();
        @(posedge core_clk);
        led_pattern <= 32'h5a3c_96e1;
        repeat (2) @(posedge core_clk);
        watch_ring(1'b0, `PKS_LED_COLS, COL_DW, 5 * COL_DW);
        watch_ring(1'b1, `PKS_KEY_ROWS, ROW_DW, FRAME + 2 * ROW_DW);
        key_event(1'b1, 4'h0, 4'hb);
        key_event(1'b1, 4'ha, 4'h0);
        key_event(1'b0, 4'ha, 4'h0);
        tally_and_finish();
    end
endmodule // tb_panel_led_key_matrix_scanner

`default_nettype wire
